/* File: supervisor_pkg.sv */
/*
 Constants, carrier structs and state types shared by the supervisor
 top, its input synchroniser and its saturating counters.
 Assumes a single 125 MHz clock domain and a synchronous active-high reset.
*/
// Functional notes
// - Each oscillator pulse restarts the ramp and starts a new switching cycle.
// - No PWM while the ramp fails to finish inside the clock period.
// - Soft-start held low until both rails good and line check passed.
// - A cycle is undervoltage when the pulse arrives before ramp reaches 90%.
// - Cycle classifications pass through a 3-bit up/down filter counter.
// - Seven good cycles assert power-good, start soft-start, gates off.
// - After soft-start, seven long-ramp cycles declare undervoltage.
// - Overcurrent comparator only looked at while high-side is driven on.
// - A trip ends the pulse and holds high-side off until next cycle.
// - Fault counter counts up on overcurrent cycles, down on clean ones.
// - At fault count seven, restart with both switches off, seven soft-starts.
// - During restart the fault counter drops once per soft-start cycle.
// - At fault count zero PWM runs again and fault counting resumes.
// - Logic off at or below 125 mV on soft-start pin, on at 210 mV.
package supervisor_pkg;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_INT_STATUS = 8'h08;
   localparam logic [7:0] OFS_INT_MASK = 8'h0c;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int NUM_IRQ = 4;
   localparam int IRQ_UV_BIT = 0;
   localparam int IRQ_PG_BIT = 1;
   localparam int IRQ_RESTART_BIT = 2;
   localparam int IRQ_OC_BIT = 3;
   localparam logic [3:0] INT_MASK_RST = 4'h0;

   // ----------------------------------------------------------------
   // Counter limits
   // ----------------------------------------------------------------
   localparam int CNT_W = 3;
   localparam logic [2:0] CNT_MAX = 3'h7;
   localparam logic [2:0] CNT_ZERO = 3'h0;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   // Comparator and detector levels from the analog side
   typedef struct packed {
      logic osc_pulse;
      logic ramp_at_90;
      logic five_volt_rail_ok;
      logic ten_volt_rail_ok;
      logic ss_above_enable;
      logic ss_above_shutdown;
      logic oc_trip;
      logic pwm_on_request;
      logic ss_cycle_done;
   } analog_in_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   typedef struct packed {
      logic hs_on;
      logic ls_on;
      logic gate_off;
      logic pwm_enable;
      logic ss_hold;
      logic ss_start;
      logic power_good;
      logic ramp_restart;
   } gate_out_t;

   typedef enum logic [1:0] {
      ST_OFF = 2'b00,
      ST_LOCKOUT = 2'b01,
      ST_RUN = 2'b10,
      ST_RESTART = 2'b11
   } mode_t;

   typedef struct packed {
      analog_in_t s1;
      analog_in_t s2;
   } sync_state_t;

   typedef struct packed {
      logic [2:0] cnt;
   } cnt_state_t;

   typedef struct packed {
      mode_t mode;
      logic logic_on;
      logic osc_prev;
      logic ssd_prev;
      logic ramp_seen;
      logic oc_seen;
      logic hs_blank;
      logic ctrl_en;
      logic [3:0] int_status;
      logic [3:0] int_mask;
      logic [31:0] rd_data;
      logic irq;
      gate_out_t out;
   } main_state_t;

endpackage

/* File: input_sync.sv */
/*
 Two-stage synchroniser for the bundle of analog comparator levels.
 Assumes every input bit is asynchronous to mclk and is a slow level.
*/
`timescale 1ns/1ns
module input_sync (
   input wire logic mclk,
   input wire logic srst,
   input supervisor_pkg::analog_in_t d,
   output supervisor_pkg::analog_in_t q
);
   supervisor_pkg::sync_state_t st_q;
   supervisor_pkg::sync_state_t st_d;

   // Stage one feeds only stage two, so metastability never reaches logic
   always_comb begin
      st_d = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.s2;
endmodule

/* File: sat_counter.sv */
/*
 Three-bit up/down counter that saturates at zero and seven.
 Assumes inc, dec and clr come from logic on mclk; clr has priority.
*/
`timescale 1ns/1ns
module sat_counter (
   input wire logic mclk,
   input wire logic srst,
   input wire logic inc,
   input wire logic dec,
   input wire logic clr,
   output logic [2:0] cnt
);
   supervisor_pkg::cnt_state_t st_q;
   supervisor_pkg::cnt_state_t st_d;

   // Saturation instead of wrap: a wrap would turn a fault burst into a clean count
   always_comb begin
      st_d = st_q;
      if (clr) begin
         st_d.cnt = supervisor_pkg::CNT_ZERO;
      end else if (inc && !dec && st_q.cnt != supervisor_pkg::CNT_MAX) begin
         st_d.cnt = st_q.cnt + 3'h1;
      end else if (dec && !inc && st_q.cnt != supervisor_pkg::CNT_ZERO) begin
         st_d.cnt = st_q.cnt - 3'h1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign cnt = st_q.cnt;

   a_cnt_top_hold: assert property (@(posedge mclk) disable iff (srst)
      (cnt == 3'h7 && inc && !dec && !clr) |=> (cnt == 3'h7))
      else $error("counter wrapped above seven");
   a_cnt_bottom_hold: assert property (@(posedge mclk) disable iff (srst)
      (cnt == 3'h0 && dec && !inc && !clr) |=> (cnt == 3'h0))
      else $error("counter wrapped below zero");
endmodule

/* File: buck_undervoltage_lockout_fault_supervisor.sv */
/*
 Supervisor for a feed-forward buck controller: low-line lockout filter,
 pulse-by-pulse current limit, hiccup fault counter and a small register port.
 Assumes analog comparator levels on the inputs, a single 125 MHz mclk and
 a register master that never issues read and write in the same cycle.
*/
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ns
module buck_undervoltage_lockout_fault_supervisor (
   input wire logic mclk,
   input wire logic srst,
   input supervisor_pkg::analog_in_t pins,
   input supervisor_pkg::bus_req_t bus,
   output logic [31:0] rd_data,
   output logic irq,
   output logic hs_on,
   output logic ls_on,
   output logic gate_off,
   output logic pwm_enable,
   output logic ss_hold,
   output logic ss_start,
   output logic power_good,
   output logic ramp_restart
);
   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   supervisor_pkg::main_state_t st_q;
   supervisor_pkg::main_state_t st_d;
   supervisor_pkg::analog_in_t a;
   logic [2:0] uv_cnt;
   logic [2:0] f_cnt;
   logic uv_inc;
   logic uv_dec;
   logic uv_clr;
   logic f_inc;
   logic f_dec;
   logic f_clr;
   logic clk_ev;
   logic ss_ev;
   logic rails_ok;
   logic [3:0] int_ev;
   logic [3:0] int_w1c;

   function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
      return addr == ofs;
   endfunction

   function automatic logic [31:0] read_word(input logic [7:0] addr,
                                             input supervisor_pkg::main_state_t s,
                                             input logic [2:0] ucnt,
                                             input logic [2:0] fcnt);
      logic [31:0] w;
      w = 32'h0;
      if (reg_hit(addr, supervisor_pkg::OFS_CTRL)) begin
         w = {31'h0, s.ctrl_en};
      end else if (reg_hit(addr, supervisor_pkg::OFS_STATUS)) begin
         w = {21'h0, fcnt, 1'b0, ucnt, s.logic_on, s.mode == supervisor_pkg::ST_RESTART,
              s.out.power_good, s.out.ss_hold};
      end else if (reg_hit(addr, supervisor_pkg::OFS_INT_STATUS)) begin
         w = {28'h0, s.int_status};
      end else if (reg_hit(addr, supervisor_pkg::OFS_INT_MASK)) begin
         w = {28'h0, s.int_mask};
      end
      return w;
   endfunction

   // ----------------------------------------------------------------
   // Input synchroniser and counters
   // ----------------------------------------------------------------
   input_sync u_sync (
      .mclk(mclk),
      .srst(srst),
      .d(pins),
      .q(a)
   );

   sat_counter u_uv_cnt (
      .mclk(mclk),
      .srst(srst),
      .inc(uv_inc),
      .dec(uv_dec),
      .clr(uv_clr),
      .cnt(uv_cnt)
   );

   sat_counter u_fault_cnt (
      .mclk(mclk),
      .srst(srst),
      .inc(f_inc),
      .dec(f_dec),
      .clr(f_clr),
      .cnt(f_cnt)
   );

   // Edges of the oscillator pulse and of the soft-start cycle marker
   assign clk_ev = a.osc_pulse && !st_q.osc_prev;
   assign ss_ev = a.ss_cycle_done && !st_q.ssd_prev;
   assign rails_ok = a.five_volt_rail_ok && a.ten_volt_rail_ok;
   assign int_w1c = (bus.wr && reg_hit(bus.addr, supervisor_pkg::OFS_INT_STATUS)) ? bus.wdata[3:0] : 4'h0;

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Counters act on the count seen this cycle, so a decision lags one clock
   always_comb begin
      st_d = st_q;
      uv_inc = 1'b0;
      uv_dec = 1'b0;
      uv_clr = 1'b0;
      f_inc = 1'b0;
      f_dec = 1'b0;
      f_clr = 1'b0;
      int_ev = 4'h0;
      st_d.osc_prev = a.osc_pulse;
      st_d.ssd_prev = a.ss_cycle_done;
      st_d.out.ss_start = 1'b0;

      // Hysteresis on the soft-start pin level
      if (!a.ss_above_shutdown) begin
         st_d.logic_on = 1'b0;
      end else if (a.ss_above_enable) begin
         st_d.logic_on = 1'b1;
      end

      // Ramp completion latch, restarted by each oscillator pulse
      if (clk_ev) begin
         st_d.ramp_seen = 1'b0;
      end else if (a.ramp_at_90) begin
         st_d.ramp_seen = 1'b1;
      end

      // Current comparator is blind while high-side is off
      if (clk_ev) begin
         st_d.oc_seen = 1'b0;
         st_d.hs_blank = 1'b0;
      end else if (st_q.out.hs_on && a.oc_trip) begin
         st_d.oc_seen = 1'b1;
         st_d.hs_blank = 1'b1;
      end
      if (clk_ev && st_q.oc_seen) begin
         int_ev[supervisor_pkg::IRQ_OC_BIT] = 1'b1;
      end

      case (st_q.mode)
         supervisor_pkg::ST_OFF: begin
            uv_clr = 1'b1;
            f_clr = 1'b1;
            if (st_d.logic_on) begin
               st_d.mode = supervisor_pkg::ST_LOCKOUT;
            end
         end
         supervisor_pkg::ST_LOCKOUT: begin
            f_clr = 1'b1;
            if (!rails_ok) begin
               uv_clr = 1'b1;
            end else if (uv_cnt == supervisor_pkg::CNT_MAX) begin
               uv_clr = 1'b1;
               st_d.mode = supervisor_pkg::ST_RUN;
               st_d.out.ss_start = 1'b1;
               int_ev[supervisor_pkg::IRQ_PG_BIT] = 1'b1;
            end else if (clk_ev) begin
               uv_inc = st_q.ramp_seen;
               uv_dec = !st_q.ramp_seen;
            end
         end
         supervisor_pkg::ST_RUN: begin
            if (!rails_ok || uv_cnt == supervisor_pkg::CNT_MAX) begin
               uv_clr = 1'b1;
               st_d.mode = supervisor_pkg::ST_LOCKOUT;
               int_ev[supervisor_pkg::IRQ_UV_BIT] = 1'b1;
            end else if (f_cnt == supervisor_pkg::CNT_MAX) begin
               st_d.mode = supervisor_pkg::ST_RESTART;
               st_d.out.ss_start = 1'b1;
               int_ev[supervisor_pkg::IRQ_RESTART_BIT] = 1'b1;
            end else if (clk_ev) begin
               uv_inc = !st_q.ramp_seen;
               uv_dec = st_q.ramp_seen;
               f_inc = st_q.oc_seen;
               f_dec = !st_q.oc_seen;
            end
         end
         supervisor_pkg::ST_RESTART: begin
            // Line filter keeps running so a brown-out still locks out
            if (!rails_ok || uv_cnt == supervisor_pkg::CNT_MAX) begin
               uv_clr = 1'b1;
               st_d.mode = supervisor_pkg::ST_LOCKOUT;
               int_ev[supervisor_pkg::IRQ_UV_BIT] = 1'b1;
            end else if (f_cnt == supervisor_pkg::CNT_ZERO) begin
               st_d.mode = supervisor_pkg::ST_RUN;
            end else begin
               if (ss_ev) begin
                  f_dec = 1'b1;
                  st_d.out.ss_start = 1'b1;
               end
               if (clk_ev) begin
                  uv_inc = !st_q.ramp_seen;
                  uv_dec = st_q.ramp_seen;
               end
            end
         end
         default: begin
            st_d.mode = supervisor_pkg::ST_OFF;
         end
      endcase

      // Logic inactive below the shutdown level overrides every mode
      if (!st_d.logic_on) begin
         st_d.mode = supervisor_pkg::ST_OFF;
         st_d.out.ss_start = 1'b0;
      end

      // Gate and soft-start outputs follow the next mode
      // Both gates stay off in the cycle that launches soft-start
      st_d.out.pwm_enable = (st_d.mode == supervisor_pkg::ST_RUN) && st_q.ctrl_en &&
                            !st_d.out.ss_start;
      st_d.out.hs_on = st_d.out.pwm_enable && a.pwm_on_request && !st_d.hs_blank;
      st_d.out.ls_on = st_d.out.pwm_enable && !st_d.out.hs_on;
      st_d.out.gate_off = !st_d.out.pwm_enable;
      st_d.out.ss_hold = (st_d.mode == supervisor_pkg::ST_OFF) ||
                         (st_d.mode == supervisor_pkg::ST_LOCKOUT);
      st_d.out.power_good = (st_d.mode == supervisor_pkg::ST_RUN) ||
                            (st_d.mode == supervisor_pkg::ST_RESTART);
      st_d.out.ramp_restart = clk_ev;

      // Register port; a new event beats a same-cycle clear
      if (bus.wr && reg_hit(bus.addr, supervisor_pkg::OFS_CTRL)) begin
         st_d.ctrl_en = bus.wdata[supervisor_pkg::CTRL_EN_BIT];
      end
      if (bus.wr && reg_hit(bus.addr, supervisor_pkg::OFS_INT_MASK)) begin
         st_d.int_mask = bus.wdata[3:0];
      end
      st_d.int_status = (st_q.int_status & ~int_w1c) | int_ev;
      st_d.rd_data = bus.rd ? read_word(bus.addr, st_q, uv_cnt, f_cnt) : 32'h0;
      st_d.irq = |(st_d.int_status & st_d.int_mask);
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_q <= '0;
         st_q.ctrl_en <= supervisor_pkg::CTRL_EN_RST;
         st_q.int_mask <= supervisor_pkg::INT_MASK_RST;
         st_q.out.gate_off <= 1'b1;
         st_q.out.ss_hold <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rd_data = st_q.rd_data;
   assign irq = st_q.irq;
   assign hs_on = st_q.out.hs_on;
   assign ls_on = st_q.out.ls_on;
   assign gate_off = st_q.out.gate_off;
   assign pwm_enable = st_q.out.pwm_enable;
   assign ss_hold = st_q.out.ss_hold;
   assign ss_start = st_q.out.ss_start;
   assign power_good = st_q.out.power_good;
   assign ramp_restart = st_q.out.ramp_restart;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);

   a_ramp_restart_pulse: assert property (clk_ev |=> ramp_restart ##1 !ramp_restart)
      else $error("ramp restart not a pulse per oscillator edge");
   a_pwm_needs_run: assert property (pwm_enable |-> st_q.mode == supervisor_pkg::ST_RUN)
      else $error("pwm enabled outside run");
   a_ss_hold_lockout: assert property ((st_q.mode == supervisor_pkg::ST_LOCKOUT) |-> ss_hold && gate_off)
      else $error("soft-start released in lockout");
   a_uv_cycle_count: assert property (st_q.mode == supervisor_pkg::ST_RUN && clk_ev && !st_q.ramp_seen &&
      uv_cnt < 3'h6 && f_cnt != 3'h7 && rails_ok && st_d.logic_on
      |=> uv_cnt == $past(uv_cnt) + 3'h1)
      else $error("late ramp not counted");
   a_pg_after_seven: assert property (st_q.mode == supervisor_pkg::ST_LOCKOUT && uv_cnt == 3'h7 &&
      rails_ok && st_d.logic_on |=> power_good && ss_start && !hs_on && !ls_on ##1 !ss_start)
      else $error("power good not raised at count seven");
   a_uv_declare: assert property (st_q.mode == supervisor_pkg::ST_RUN && uv_cnt == 3'h7 && st_d.logic_on
      |=> st_q.mode == supervisor_pkg::ST_LOCKOUT && !power_good)
      else $error("undervoltage not declared at count seven");
   a_oc_ignored_off: assert property (!hs_on && !st_q.oc_seen && !clk_ev |=> !st_q.oc_seen)
      else $error("trip sampled with high side off");
   a_hs_cut_trip: assert property (hs_on && a.oc_trip && !clk_ev |=> !hs_on && st_q.hs_blank)
      else $error("pulse not ended on trip");
   a_fault_count_up: assert property (st_q.mode == supervisor_pkg::ST_RUN && clk_ev && st_q.oc_seen &&
      f_cnt < 3'h6 && uv_cnt != 3'h7 && rails_ok && st_d.logic_on
      |=> f_cnt == $past(f_cnt) + 3'h1)
      else $error("fault counter missed an overcurrent cycle");
   a_restart_gates: assert property (st_q.mode == supervisor_pkg::ST_RESTART |-> gate_off && !hs_on && !ls_on)
      else $error("switch driven during restart");
   a_restart_step: assert property (st_q.mode == supervisor_pkg::ST_RESTART && ss_ev && f_cnt != 3'h0 &&
      uv_cnt != 3'h7 && rails_ok && st_d.logic_on |=> f_cnt == $past(f_cnt) - 3'h1)
      else $error("fault counter not stepped per soft-start cycle");
   a_restart_exit: assert property (st_q.mode == supervisor_pkg::ST_RESTART && f_cnt == 3'h0 &&
      uv_cnt != 3'h7 && rails_ok && st_d.logic_on |=> st_q.mode == supervisor_pkg::ST_RUN)
      else $error("pwm not re-enabled at fault count zero");
   a_logic_off_low: assert property (!a.ss_above_shutdown |=> st_q.mode == supervisor_pkg::ST_OFF && ss_hold)
      else $error("logic active below shutdown level");

   c_power_up: cover property (st_q.mode == supervisor_pkg::ST_LOCKOUT ##1 st_q.mode == supervisor_pkg::ST_RUN);
   c_hiccup: cover property (st_q.mode == supervisor_pkg::ST_RUN ##1 st_q.mode == supervisor_pkg::ST_RESTART);
   c_recover: cover property (st_q.mode == supervisor_pkg::ST_RESTART ##1 st_q.mode == supervisor_pkg::ST_RUN);
   c_brownout: cover property (st_q.mode == supervisor_pkg::ST_RUN ##1 st_q.mode == supervisor_pkg::ST_LOCKOUT);
endmodule

/* File: analog_side_model.sv */
/*
 Analog side model: oscillator, feed-forward ramp comparator, rail and
 soft-start detectors, current comparator.
 Assumes the bench steers it through plain control levels.
*/
`timescale 1ns/1ns
module analog_side_model (
   input wire logic mclk,
   input wire logic srst,
   input wire logic hs_on,
   input wire logic rails,
   input wire logic line_ok,
   input wire logic oc_fault,
   input wire logic oc_force,
   input wire logic ss_run,
   input wire logic ss_low,
   output supervisor_pkg::analog_in_t pins
);
   logic [4:0] phase_q;
   logic line_q;
   // ------------------------------------------------------------
   // Oscillator period of 24 clocks
   // ------------------------------------------------------------
   // Line level latched per period, so a bench change never cuts a ramp short
   always_ff @(posedge mclk) begin
      if (srst || phase_q == 5'h17) begin
         phase_q <= 5'h00;
         line_q <= line_ok;
      end else begin
         phase_q <= phase_q + 5'h01;
      end
   end
   // Comparator levels; a low line keeps the ramp from ever reaching 90%
   always_comb begin
      pins.osc_pulse = phase_q < 5'h02;
      pins.ramp_at_90 = line_q && phase_q >= 5'h0a;
      pins.five_volt_rail_ok = rails;
      pins.ten_volt_rail_ok = rails;
      pins.ss_above_enable = !ss_low;
      pins.ss_above_shutdown = !ss_low;
      pins.pwm_on_request = phase_q >= 5'h02 && phase_q < 5'h10;
      pins.oc_trip = oc_force || (oc_fault && hs_on);
      pins.ss_cycle_done = ss_run && phase_q >= 5'h04 && phase_q < 5'h08;
   end
endmodule

/* File: test_buck_undervoltage_lockout_fault_supervisor.sv */
/*
 Self-checking bench: reset checks, a table of line, rail and fault cases,
 then trip, filter boundary, register and interrupt tests.
 Assumes the package, design files and analog side model compile first.
*/
`timescale 1ns/1ns
module test_buck_undervoltage_lockout_fault_supervisor;
   typedef struct packed {
      logic rails;
      logic line;
      logic oc;
      logic ssr;
      logic [7:0] nosc;
      logic [3:0] exp;
      logic [3:0] msk;
   } row_t;
   logic mclk, srst, irq, hs_on, ls_on, gate_off, pwm_enable, ss_hold, ss_start, power_good, ramp_restart;
   logic rails, line_ok, oc_fault, oc_force, ss_run, ss_low;
   logic [31:0] rd_data;
   logic [31:0] d;
   supervisor_pkg::analog_in_t pins;
   supervisor_pkg::bus_req_t bus;
   row_t rows [0:8];
   int err_total, cmp_count, k, n, starts;

   buck_undervoltage_lockout_fault_supervisor i_dut (.mclk(mclk), .srst(srst), .pins(pins), .bus(bus), .rd_data(rd_data),
      .irq(irq), .hs_on(hs_on), .ls_on(ls_on), .gate_off(gate_off), .pwm_enable(pwm_enable), .ss_hold(ss_hold),
      .ss_start(ss_start), .power_good(power_good), .ramp_restart(ramp_restart));
   analog_side_model i_far (.mclk(mclk), .srst(srst), .hs_on(hs_on), .rails(rails), .line_ok(line_ok),
      .oc_fault(oc_fault), .oc_force(oc_force), .ss_run(ss_run), .ss_low(ss_low), .pins(pins));

   // ------------------------------------------------------------
   // Clock, watchdog and shared tasks
   // ------------------------------------------------------------
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // A hang counts as a mismatch and still reaches the verdict
   initial begin
      #400000;
      err_total++;
      stop_test();
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Counts soft-start pulses on the way, so a double start is seen
   task automatic cyc(input int c);
      repeat (c) begin
         @(posedge mclk);
         starts += int'(ss_start === 1'b1);
      end
   endtask
   // Returns at the edge that first samples a new oscillator pulse
   task automatic wait_osc(input int c);
      logic prev;
      prev = 1'b1;
      for (int i = 0; i < 4000 && c > 0; i++) begin
         @(posedge mclk);
         if (pins.osc_pulse && !prev) c--;
         prev = pins.osc_pulse;
      end
      if (c > 0) begin
         err_total++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge mclk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge mclk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge mclk);
      bus.rd <= 1'b0;
      #1 v = rd_data;
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      srst = 1'b1;
      bus = '0;
      {rails, line_ok, oc_fault, oc_force, ss_run, ss_low} = 6'b110000;
      err_total = 0;
      cmp_count = 0;
      starts = 0;
      rows[0] = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h0c, 4'hc, 4'hf};
      rows[1] = '{1'b1, 1'b0, 1'b0, 1'b0, 8'h0c, 4'h3, 4'hf};
      rows[2] = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h0c, 4'hc, 4'hf};
      rows[3] = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h0c, 4'h2, 4'h6};
      rows[4] = '{1'b1, 1'b1, 1'b0, 1'b1, 8'h0c, 4'h4, 4'h6};
      rows[5] = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h0c, 4'h2, 4'h6};
      rows[6] = '{1'b1, 1'b1, 1'b0, 1'b1, 8'h0c, 4'hc, 4'hf};
      rows[7] = '{1'b0, 1'b1, 1'b0, 1'b0, 8'h01, 4'h1, 4'h5};
      rows[8] = '{1'b1, 1'b1, 1'b0, 1'b0, 8'h0c, 4'hc, 4'hf};
      cyc(2);
      check("reset outputs", 32'h28, {23'h0, irq, hs_on, ls_on, gate_off, pwm_enable, ss_hold, ss_start,
         power_good, ramp_restart});
      srst <= 1'b0;
      rd(supervisor_pkg::OFS_STATUS, d);
      check("counters after reset", 32'h0, d & 32'h770);
      rd(supervisor_pkg::OFS_CTRL, d);
      check("ctrl reset", 32'h1, d);
      rd(supervisor_pkg::OFS_INT_MASK, d);
      check("mask reset", 32'h0, d);
      $display("reset test done");
      // Table of line, rail, overcurrent and restart cases
      foreach (rows[i]) begin
         @(posedge mclk);
         {rails, line_ok, oc_fault, ss_run} <= {rows[i].rails, rows[i].line, rows[i].oc, rows[i].ssr};
         wait_osc(int'(rows[i].nosc));
         cyc(12);
         check("row outputs", {28'h0, rows[i].exp & rows[i].msk}, {28'h0, {power_good, pwm_enable, gate_off,
            ss_hold} & rows[i].msk});
         $display("row %0d done", i);
      end
      // One tripped pulse: high side must stay off until the next cycle
      @(posedge mclk);
      oc_fault <= 1'b1;
      for (k = 0; k < 60 && hs_on !== 1'b1; k++) @(posedge mclk);
      for (n = 0; n < 10 && hs_on !== 1'b0; n++) @(posedge mclk);
      oc_fault <= 1'b0;
      check("trip to gate off", 32'h1, {31'h0, k < 60 && n < 6});
      n = 0;
      for (k = 0; k < 40 && ramp_restart !== 1'b1; k++) begin
         @(posedge mclk);
         n += int'(hs_on !== 1'b0);
      end
      check("high side after trip", 32'h0, n + int'(k >= 40));
      $display("trip test done");
      // Comparator trips while the high side is off must not count
      wr(supervisor_pkg::OFS_CTRL, 32'h0);
      cyc(3);
      check("forced off", 32'h1, {30'h0, pwm_enable, gate_off});
      @(posedge mclk);
      oc_force <= 1'b1;
      wait_osc(10);
      rd(supervisor_pkg::OFS_STATUS, d);
      check("fault count idle", 32'h0, d & 32'h700);
      @(posedge mclk);
      oc_force <= 1'b0;
      wr(supervisor_pkg::OFS_CTRL, 32'h1);
      wr(supervisor_pkg::OFS_INT_STATUS, 32'hf);
      wr(supervisor_pkg::OFS_INT_MASK, 32'h2);
      cyc(2);
      check("irq idle", 32'h0, {31'h0, irq});
      $display("idle trip test done");
      // Filter boundaries: six bad cycles hold on, the seventh drops out
      wait_osc(1);
      line_ok <= 1'b0;
      wait_osc(7);
      cyc(12);
      check("good after six late", 32'h1, {31'h0, power_good});
      wait_osc(1);
      cyc(12);
      check("good after seven late", 32'h0, {31'h0, power_good});
      wait_osc(8);
      line_ok <= 1'b1;
      wait_osc(7);
      cyc(12);
      check("good after six short", 32'h0, {31'h0, power_good});
      starts = 0;
      wait_osc(1);
      cyc(12);
      check("good after seven short", 32'h1, {31'h0, power_good});
      check("soft-start pulses", 32'h1, starts);
      $display("filter test done");
      // Sticky status, mask, write-one-to-clear and an unmapped place
      rd(supervisor_pkg::OFS_INT_STATUS, d);
      check("int status", 32'h3, d & 32'hf);
      check("irq masked in", 32'h1, {31'h0, irq});
      wr(supervisor_pkg::OFS_INT_STATUS, 32'h2);
      cyc(2);
      check("irq cleared", 32'h0, {31'h0, irq});
      rd(supervisor_pkg::OFS_INT_STATUS, d);
      check("int status left", 32'h1, d & 32'hf);
      wr(supervisor_pkg::OFS_INT_MASK, 32'h1);
      cyc(2);
      check("irq other bit", 32'h1, {31'h0, irq});
      rd(8'h10, d);
      check("unmapped read", 32'h0, d);
      $display("register test done");
      // Soft-start pin pulled low: logic off, soft-start held, no switching
      @(posedge mclk);
      ss_low <= 1'b1;
      cyc(6);
      check("shutdown outputs", 32'h3, {28'h0, power_good, pwm_enable, gate_off, ss_hold});
      $display("shutdown test done");
      stop_test();
   end
endmodule
